// ==== rtl/pts_sideband.sv ====
`timescale 1ns/1ps
// Functional notes
// - stop burst only acts during master data
// - clear empties target fifos and state counter
// - clear leaves pci target responses untouched
// - ready low in reset, clear, startup wait
// - report target fifo state on four bits
// - expiry drops delayed txn, flags fabric
// - fifteen-bit discard timer starts on store
// - abort request makes cycles target-abort
// - retry request makes cycles retry
// - delayed request delays reads and io writes
module pts_sideband #(
    parameter logic [14:0] DISCARD_LIMIT = pts_pkg::DISCARD_LIMIT_DFLT
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // fabric side requests
    input  wire logic        master_read_stop_burst_n_i,
    input  wire logic        target_fifo_clear_n_i,
    input  wire logic        target_abort_i,
    input  wire logic        target_retry_n_i,
    input  wire logic        delayed_txn_n_i,
    // core side status
    input  wire logic        pci_rst_i,
    input  wire logic        master_data_phase_i,
    input  wire logic        tgt_cycle_start_i,
    input  wire logic [3:0]  tgt_cmd_i,
    input  wire logic        tgt_addr_taken_i,
    input  wire logic        tgt_data_done_i,
    input  wire logic        dly_complete_i,
    // to master controller
    output logic             master_stop_burst_o,
    // to target controller
    output logic             resp_abort_o,
    output logic             resp_retry_o,
    output logic             resp_delayed_o,
    output logic             target_fifo_flush_o,
    output logic             dly_discard_o,
    // to fabric
    output logic             target_ready_o,
    output logic [3:0]       target_state_cntr_o,
    output logic             discard_expired_n_o
);
    import pts_pkg::*;

    // request qualification
    logic [REQ_NUM-1:0] req_raw;
    logic [REQ_NUM-1:0] req_held;

    assign req_raw[REQ_STOP]  = ~master_read_stop_burst_n_i;
    assign req_raw[REQ_ABORT] = target_abort_i;
    assign req_raw[REQ_RETRY] = ~target_retry_n_i;
    assign req_raw[REQ_DELAY] = ~delayed_txn_n_i;

    pts_req_filter u_filter (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .req_i     (req_raw),
        .held_o    (req_held)
    );

    // clear input is asynchronous to us, so its release is resynchronised
    logic clear_n_sync;

    pts_sync2 #(
        .RST_VAL (1'b0)
    ) u_clear_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .async_i   (target_fifo_clear_n_i),
        .sync_o    (clear_n_sync)
    );

    wire logic clear_act = ~clear_n_sync;

    // master read early stop
    wire logic stop_nxt = req_held[REQ_STOP] & master_data_phase_i;

    // target cycle response; abort wins over retry, retry over delay
    wire logic cmd_delayable = (tgt_cmd_i == CMD_IO_READ)
                             | (tgt_cmd_i == CMD_IO_WRITE)
                             | (tgt_cmd_i == CMD_MEM_READ)
                             | (tgt_cmd_i == CMD_MEM_READ_MULT)
                             | (tgt_cmd_i == CMD_MEM_READ_LINE);

    wire logic abort_nxt = tgt_cycle_start_i & req_held[REQ_ABORT];
    wire logic retry_nxt = tgt_cycle_start_i & ~req_held[REQ_ABORT]
                         & req_held[REQ_RETRY];

    logic dly_valid_r;
    // only one delayed transaction is stored; a further delayable cycle
    // while one is pending is answered with retry by the controller
    wire logic dly_store = tgt_cycle_start_i & ~req_held[REQ_ABORT]
                         & ~req_held[REQ_RETRY] & req_held[REQ_DELAY]
                         & cmd_delayable & ~dly_valid_r;

    // discard timer
    logic [DISCARD_W-1:0] disc_cnt_r;
    wire logic            disc_expire = dly_valid_r & (disc_cnt_r == DISCARD_LIMIT);
    wire logic            disc_run    = dly_valid_r & ~disc_expire & ~dly_complete_i;

    logic [DISCARD_W-1:0] disc_cnt_nxt;
    always_comb begin
        if (dly_store) begin
            disc_cnt_nxt = DISCARD_RST;
        end else if (disc_run) begin
            disc_cnt_nxt = disc_cnt_r + 15'h0001;
        end else begin
            disc_cnt_nxt = disc_cnt_r;
        end
    end

    wire logic dly_valid_nxt = dly_store | (dly_valid_r & ~disc_expire & ~dly_complete_i);

    // pci facing state is not touched by the fifo clear
    always_ff @(posedge clk_sys_i) begin
        if (rst_i | pci_rst_i) begin
            master_stop_burst_o <= 1'b0;
            resp_abort_o        <= 1'b0;
            resp_retry_o        <= 1'b0;
            resp_delayed_o      <= 1'b0;
            dly_valid_r         <= 1'b0;
            disc_cnt_r          <= DISCARD_RST;
            dly_discard_o       <= 1'b0;
            discard_expired_n_o <= 1'b1;
        end else begin
            master_stop_burst_o <= stop_nxt;
            resp_abort_o        <= abort_nxt;
            resp_retry_o        <= retry_nxt;
            resp_delayed_o      <= dly_store;
            dly_valid_r         <= dly_valid_nxt;
            disc_cnt_r          <= disc_cnt_nxt;
            dly_discard_o       <= disc_expire;
            discard_expired_n_o <= ~disc_expire;
        end
    end

    // target fifo interface state, reported to the fabric
    pts_tstate_t tstate_r;
    pts_tstate_t tstate_nxt;

    always_comb begin
        tstate_nxt = tstate_r;
        case (tstate_r)
            TS_IDLE: begin
                if (dly_store) begin
                    tstate_nxt = TS_DELAYED;
                end else if (tgt_cycle_start_i & ~abort_nxt & ~retry_nxt) begin
                    tstate_nxt = TS_ADDR;
                end
            end
            TS_ADDR: begin
                if (tgt_addr_taken_i) begin
                    tstate_nxt = tgt_cmd_i[0] ? TS_WRITE : TS_READ;
                end
            end
            TS_WRITE, TS_READ: begin
                if (tgt_data_done_i) begin
                    tstate_nxt = TS_DONE;
                end
            end
            TS_DELAYED: begin
                if (disc_expire) begin
                    tstate_nxt = TS_IDLE;
                end else if (dly_complete_i) begin
                    tstate_nxt = TS_DONE;
                end
            end
            TS_DONE: begin
                tstate_nxt = TS_IDLE;
            end
            default: begin
                tstate_nxt = TS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i | pci_rst_i | clear_act) begin
            tstate_r <= TS_IDLE;
        end else begin
            tstate_r <= tstate_nxt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i | clear_act) begin
            target_state_cntr_o <= STATE_RST;
        end else begin
            target_state_cntr_o <= tstate_nxt;
        end
    end

    // fifo flush lasts as long as the clear, delayed by the synchroniser and one register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            target_fifo_flush_o <= 1'b1;
        end else begin
            target_fifo_flush_o <= clear_act;
        end
    end

    // ready after startup wait and outside reset or clear
    logic [READY_CNT_W-1:0] ready_cnt_r;
    wire logic              ready_wait_done = (ready_cnt_r == READY_CNT_W'(READY_WAIT_CYCLES));

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ready_cnt_r <= '0;
        end else if (!ready_wait_done) begin
            ready_cnt_r <= ready_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            target_ready_o <= 1'b0;
        end else begin
            target_ready_o <= ready_wait_done & ~pci_rst_i & ~clear_act;
        end
    end

endmodule

// ==== rtl/pts_pkg.sv ====
package pts_pkg;

    // wait after configuration before the target fifo side reports ready
    localparam int unsigned READY_WAIT_CYCLES = 16;
    localparam int unsigned READY_CNT_W       = 5;

    // discard timer
    localparam int unsigned DISCARD_W          = 15;
    localparam logic [14:0] DISCARD_LIMIT_DFLT = 15'h7fff;
    localparam logic [14:0] DISCARD_RST        = 15'h0000;

    // a request counts once seen on this many consecutive edges
    localparam int unsigned REQ_HOLD_CYCLES = 2;
    localparam int unsigned REQ_NUM         = 4;
    localparam int unsigned REQ_STOP        = 0;
    localparam int unsigned REQ_ABORT       = 1;
    localparam int unsigned REQ_RETRY       = 2;
    localparam int unsigned REQ_DELAY       = 3;

    // pci command codes that may be turned into delayed transactions
    localparam logic [3:0] CMD_IO_READ       = 4'h2;
    localparam logic [3:0] CMD_IO_WRITE      = 4'h3;
    localparam logic [3:0] CMD_MEM_READ      = 4'h6;
    localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
    localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;

    localparam int unsigned STATE_W = 4;
    localparam logic [3:0]  STATE_RST = 4'h0;

    typedef enum logic [3:0] {
        TS_IDLE,
        TS_ADDR,
        TS_WRITE,
        TS_READ,
        TS_DELAYED,
        TS_DONE
    } pts_tstate_t;

endpackage

// ==== rtl/pts_sync2.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for a level; reset value is a parameter constant
module pts_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      sync_o
);
    import pts_pkg::*;

    logic meta_r;
    logic sync_r;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule

// ==== rtl/pts_req_filter.sv ====
`timescale 1ns/1ps
// a request is taken only after it has stood for REQ_HOLD_CYCLES edges,
// so a one-cycle glitch from the fabric never reaches the target logic
module pts_req_filter (
    input  wire logic                          clk_sys_i,
    input  wire logic                          rst_i,
    input  wire logic [pts_pkg::REQ_NUM-1:0]   req_i,
    output logic      [pts_pkg::REQ_NUM-1:0]   held_o
);
    import pts_pkg::*;

    genvar g;
    generate
        for (g = 0; g < REQ_NUM; g++) begin : g_req
            logic [REQ_HOLD_CYCLES-1:0] hist_r;
            logic                       held_r;
            wire logic                  all_seen = &{hist_r[REQ_HOLD_CYCLES-2:0], req_i[g]};
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    hist_r <= '0;
                    held_r <= 1'b0;
                end else begin
                    hist_r <= {hist_r[REQ_HOLD_CYCLES-2:0], req_i[g]};
                    held_r <= all_seen;
                end
            end
            assign held_o[g] = held_r;
        end
    endgenerate

endmodule

// ==== tb/pts_sideband_chk.sv ====
`timescale 1ns/1ps
module pts_sideband_chk (
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic       master_read_stop_burst_n_i,
    input wire logic       target_fifo_clear_n_i,
    input wire logic       target_abort_i,
    input wire logic       target_retry_n_i,
    input wire logic       pci_rst_i,
    input wire logic       master_data_phase_i,
    input wire logic       tgt_cycle_start_i,
    input wire logic       master_stop_burst_o,
    input wire logic       resp_abort_o,
    input wire logic       resp_retry_o,
    input wire logic       resp_delayed_o,
    input wire logic       target_fifo_flush_o,
    input wire logic       dly_discard_o,
    input wire logic       target_ready_o,
    input wire logic [3:0] target_state_cntr_o,
    input wire logic       discard_expired_n_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // windows are a little longer than the filter needs, so a lingering flag is gone
    sequence s_abort; (target_abort_i && !pci_rst_i)[*5]; endsequence
    sequence s_retry; (!target_retry_n_i && !target_abort_i && !pci_rst_i)[*5]; endsequence
    sequence s_stop; (!master_read_stop_burst_n_i && master_data_phase_i && !pci_rst_i)[*6];
    endsequence
    sequence s_clear; (!target_fifo_clear_n_i)[*4]; endsequence
    AST_PCI_RST_READY: assert property (pci_rst_i |=> !target_ready_o)
        else $error("ready after pci reset");
    AST_CLEAR: assert property (s_clear |-> target_fifo_flush_o && !target_ready_o
        && target_state_cntr_o == 4'h0) else $error("clear not applied");
    AST_STOP_IDLE: assert property (!master_data_phase_i |=> !master_stop_burst_o)
        else $error("stop without data phase");
    AST_STOP_TAKE: assert property (s_stop |-> master_stop_burst_o)
        else $error("stop not taken");
    AST_RESP_CAUSE: assert property ((resp_abort_o || resp_retry_o || resp_delayed_o)
        |-> $past(tgt_cycle_start_i) && $onehot({resp_abort_o, resp_retry_o, resp_delayed_o}))
        else $error("answer without cycle");
    AST_ABORT: assert property (s_abort ##0 tgt_cycle_start_i |=> resp_abort_o)
        else $error("abort not answered");
    AST_RETRY: assert property (s_retry ##0 tgt_cycle_start_i |=> resp_retry_o)
        else $error("retry not answered");
    AST_EXPIRE: assert property (!discard_expired_n_o |-> dly_discard_o
        ##1 discard_expired_n_o) else $error("expiry pulse wrong");
endmodule
bind pts_sideband pts_sideband_chk chk (.*);

// ==== tb/pts_fab_model.sv ====
`timescale 1ns/1ps
// fabric side: each wish becomes a request pin kept for two edges at least unless short_i is set
module pts_fab_model (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] want_i,
    input  wire logic       short_i,
    output logic            stop_n_o,
    output logic            abort_o,
    output logic            retry_n_o,
    output logic            delay_n_o
);
    logic [3:0] act_r;
    logic [3:0] old_r;
    // short_i breaks the minimum hold on purpose, to show a glitch is ignored
    always_ff @(posedge clk_sys_i) begin
        act_r <= rst_i ? 4'h0 : (want_i | (act_r & ~old_r & ~{4{short_i}}));
        old_r <= act_r;
    end
    assign stop_n_o  = ~act_r[0];
    assign abort_o   = act_r[1];
    assign retry_n_o = ~act_r[2];
    assign delay_n_o = ~act_r[3];
endmodule

// ==== tb/pts_sideband_tb_top.sv ====
`timescale 1ns/1ps
module pts_sideband_tb_top;
    import pts_pkg::*;
    localparam logic [14:0] DLIM = 15'h0010;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  want = 4'h0;
    logic [3:0]  cmd = 4'h0;
    logic [2:0]  pls = 3'h0;
    logic        short = 1'b0, clr_n = 1'b1, prst = 1'b0, dph = 1'b0, start = 1'b0;
    logic        stop_n, abrt, rty_n, dly_n, mstop, r_ab, r_rt, r_dl, flush, disc, rdy, exp_n;
    logic [3:0]  st;
    int          err_count = 0;
    int          check_count = 0;
    int          n;
    // {0,abort,retry_n,delay_n} cmd {0,abort,retry,delayed} state
    logic [15:0] rows [11] = '{16'h3601, 16'h7640, 16'h1620, 16'h2214, 16'h2314, 16'h2614,
                               16'h2c14, 16'h2e14, 16'h2701, 16'h4640, 16'h0620};
    pts_fab_model fab (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .want_i(want), .short_i(short),
        .stop_n_o(stop_n), .abort_o(abrt), .retry_n_o(rty_n), .delay_n_o(dly_n));
    pts_sideband #(.DISCARD_LIMIT(DLIM)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .master_read_stop_burst_n_i(stop_n), .target_fifo_clear_n_i(clr_n),
        .target_abort_i(abrt), .target_retry_n_i(rty_n), .delayed_txn_n_i(dly_n),
        .pci_rst_i(prst), .master_data_phase_i(dph), .tgt_cycle_start_i(start),
        .tgt_cmd_i(cmd), .tgt_addr_taken_i(pls[2]), .tgt_data_done_i(pls[1]),
        .dly_complete_i(pls[0]), .master_stop_burst_o(mstop), .resp_abort_o(r_ab),
        .resp_retry_o(r_rt), .resp_delayed_o(r_dl), .target_fifo_flush_o(flush),
        .dly_discard_o(disc), .target_ready_o(rdy), .target_state_cntr_o(st),
        .discard_expired_n_o(exp_n));
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic end_sim();
        if (err_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask
    // w=0 waits for ready, w=1 for the expiry flag; n counts edges
    task automatic wt(input bit w, input int n0);
        n = n0;
        while ((w ? exp_n : ~rdy) === 1'b1 && n < 60) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n >= 60) begin
            err_count++;
            end_sim();
        end
    endtask
    task automatic hit(input logic [3:0] c, input logic [2:0] er, input logic [3:0] es);
        cyc(1);
        start <= 1'b1;
        cmd <= c;
        cyc(1);
        start <= 1'b0;
        @(negedge clk_sys_i);
        chk(16'({r_ab, r_rt, r_dl}), 16'(er));
        chk(16'(st), 16'(es));
    endtask
    // walks any open transaction back to idle
    task automatic clean();
        cyc(1);
        want <= 4'h0;
        for (int k = 2; k >= 0; k--) begin
            pls <= 3'(1 << k);
            cyc(1);
        end
        pls <= 3'h0;
        cyc(3);
        @(negedge clk_sys_i);
        chk(16'(st), 16'h0);
    endtask
    initial begin
        cyc(5);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(16'({rdy, flush, st, exp_n}), 16'h21);
        wt(1'b0, 0);
        chk(16'(n), 16'(READY_WAIT_CYCLES + 1));
        foreach (rows[i]) begin
            cyc(1);
            want <= {~rows[i][12], ~rows[i][13], rows[i][14], 1'b0};
            cyc(5);
            hit(rows[i][11:8], rows[i][6:4], rows[i][3:0]);
            clean();
        end
        cyc(1);
        short <= 1'b1;
        want <= 4'h2;
        cyc(1);
        want <= 4'h0;
        cyc(4);
        short <= 1'b0;
        hit(4'h6, 3'h0, 4'h1);
        cyc(1);
        clr_n <= 1'b0;
        want <= 4'h2;
        cyc(5);
        @(negedge clk_sys_i);
        chk(16'({flush, rdy, st}), 16'h20);
        hit(4'h6, 3'h4, 4'h0);
        cyc(1);
        clr_n <= 1'b1;
        wt(1'b0, 0);
        clean();
        chk(16'(flush), 16'h0);
        cyc(1);
        want <= 4'h1;
        cyc(6);
        @(negedge clk_sys_i);
        chk(16'(mstop), 16'h0);
        cyc(1);
        dph <= 1'b1;
        cyc(6);
        @(negedge clk_sys_i);
        chk(16'(mstop), 16'h1);
        cyc(1);
        want <= 4'h0;
        cyc(5);
        @(negedge clk_sys_i);
        chk(16'(mstop), 16'h0);
        cyc(1);
        want <= 4'h8;
        cyc(5);
        hit(4'h6, 3'h1, 4'h4);
        hit(4'h6, 3'h0, 4'h4);
        wt(1'b1, 2);
        chk(16'(n), 16'(DLIM) + 16'h1);
        chk(16'(disc), 16'h1);
        cyc(1);
        want <= 4'h0;
        prst <= 1'b1;
        cyc(2);
        @(negedge clk_sys_i);
        chk(16'(rdy), 16'h0);
        cyc(1);
        prst <= 1'b0;
        wt(1'b0, 0);
        end_sim();
    end
endmodule
